//--- hdl/rit_regs.svh
// Constants for the release interval timer
`ifndef RIT_REGS_SVH
`define RIT_REGS_SVH

`define RIT_CLK_HZ        100000000
`define RIT_BASE_HZ       18641
`define RIT_DIV1_BITS     14
`define RIT_DIV2_BITS     12
`define RIT_FILT_NS       3000
`define RIT_CLK_NS        10
`define RIT_FILT_CYC      ((`RIT_FILT_NS + `RIT_CLK_NS - 1) / `RIT_CLK_NS)
`define RIT_DIGITS        4
`define RIT_BCD_MAX       4'h9
`define RIT_BCD_ZERO      4'h0
`define RIT_NCO_W         32

`endif

//--- hdl/rit_pkg.sv
// Types for the release interval timer
package rit_pkg;
    typedef logic [3:0] rit_digit_t;
    typedef struct packed {
        rit_digit_t d3;
        rit_digit_t d2;
        rit_digit_t d1;
        rit_digit_t d0;
    } rit_bcd_t;
    typedef struct packed {
        logic norm_sel;
        logic test_sel;
    } rit_sel_t;
    typedef enum logic [1:0] {
        RIT_ST_COUNT = 2'b00,
        RIT_ST_ZERO  = 2'b01,
        RIT_ST_FIRED = 2'b10
    } rit_state_t;
endpackage : rit_pkg

//--- hdl/rit_sync.sv
// Three-stage input synchroniser with agreement check
module rit_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out,
    output logic      [WIDTH-1:0] rise_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] val;
        logic [WIDTH-1:0] rise;
    } rit_sync_st_t;

    rit_sync_st_t st_ff;
    rit_sync_st_t nxt_st;

    initial begin
        if (WIDTH < 1)
        begin
            $error("rit_sync: WIDTH must be positive");
        end
    end

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.s1 = async_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // Change counts only once stages two and three agree
        for (int i = 0; i < WIDTH; i++)
        begin
            if (st_ff.s2[i] == st_ff.s3[i])
            begin
                nxt_st.val[i] = st_ff.s3[i];
            end
        end
        nxt_st.rise = nxt_st.val & ~st_ff.val;
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign sync_out = st_ff.val;
    assign rise_out = st_ff.rise;
endmodule // rit_sync

//--- hdl/rit_timer.sv
// Release interval timer: dividers, select, BCD down counter, fire
//
// Functional notes
// - First divider turns the 18641 Hz time base into 1.1378 Hz.
// - Select gate feeds second divider from first divider or test clock.
// - Second divider emits one pulse per 4096 inputs, hourly nominal.
// - Four-digit BCD down counter decrements once per second-divider pulse.
// - Interval is 1 to 9999 whole hours from four BCD switch digits.
// - Load input copies switch digits into all four decades.
// - Zero detect goes high when all four decades are zero.
// - Zero detect is filtered so ripple glitches cannot fire.
// - Fire asserts after zero has persisted about 3 microseconds.
// - Fire output drives the firing stage of the release.
// - Normal high and test low routes first divider to second.
// - Normal low and test high routes external test clock to second.
// - Fire stays active until reset or until the load input is asserted again.
`include "rit_regs.svh"
module rit_timer #(
    parameter int          DIV1_BITS = `RIT_DIV1_BITS,
    parameter int          DIV2_BITS = `RIT_DIV2_BITS,
    parameter int          FILT_CYC  = `RIT_FILT_CYC,
    parameter int unsigned CLK_HZ    = `RIT_CLK_HZ,
    parameter int unsigned BASE_HZ   = `RIT_BASE_HZ
) (
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             load_in,
    input  wire rit_pkg::rit_bcd_t switch_in,
    input  wire rit_pkg::rit_sel_t sel_in,
    input  wire logic             test_clk_in,
    output logic                  fire_out,
    output logic                  zero_out,
    output logic                  hour_tick_out,
    output rit_pkg::rit_bcd_t     count_out
);
    import rit_pkg::*;

    localparam int FW = $clog2(FILT_CYC + 1);
    localparam logic [`RIT_NCO_W-1:0] NCO_INC =
        `RIT_NCO_W'(BASE_HZ);
    localparam logic [`RIT_NCO_W-1:0] NCO_MOD =
        `RIT_NCO_W'(CLK_HZ);

    typedef struct packed {
        logic [`RIT_NCO_W-1:0] nco;
        logic [DIV1_BITS-1:0]  div1;
        logic                  div1_q;
        logic                  mux_q;
        logic [DIV2_BITS-1:0]  div2;
        logic                  tick;
        rit_bcd_t              cnt;
        logic                  zero;
        logic [FW-1:0]         filt;
        rit_state_t            state;
        logic                  fire;
    } rit_st_t;

    rit_st_t st_ff;
    rit_st_t nxt_st;

    logic [3:0] s_sync;
    logic [3:0] s_rise;

    initial begin
        if (DIV1_BITS < 1 || DIV2_BITS < 1 || FILT_CYC < 1)
        begin
            $error("rit_timer: divider and filter sizes must be positive");
        end
        if (BASE_HZ == 0 || BASE_HZ >= CLK_HZ)
        begin
            $error("rit_timer: time base must be below the clock rate");
        end
    end

    // Pins from outside: load, two selects, test clock
    rit_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .async_in   ({load_in, sel_in.norm_sel, sel_in.test_sel,
                      test_clk_in}),
        .sync_out   (s_sync),
        .rise_out   (s_rise)
    );

    function automatic rit_digit_t bcd_dec(input rit_digit_t d);
        bcd_dec = (d == `RIT_BCD_ZERO) ? `RIT_BCD_MAX : d - 4'h1;
    endfunction

    function automatic rit_digit_t bcd_clip(input rit_digit_t d);
        // Illegal switch codes are clipped to nine
        bcd_clip = (d > `RIT_BCD_MAX) ? `RIT_BCD_MAX : d;
    endfunction

    logic load_s;
    logic norm_s;
    logic test_s;
    logic tclk_s;
    logic mux_src;
    logic [`RIT_NCO_W:0] nco_sum;

    assign load_s = s_sync[3];
    assign norm_s = s_sync[2];
    assign test_s = s_sync[1];
    assign tclk_s = s_sync[0];

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.tick = 1'b0;
        mux_src = 1'b0;
        // Fractional accumulator stands in for the crystal
        nco_sum = {1'b0, st_ff.nco} + {1'b0, NCO_INC};
        if (nco_sum >= {1'b0, NCO_MOD})
        begin
            nco_sum = nco_sum - {1'b0, NCO_MOD};
            nxt_st.div1 = st_ff.div1 + 1'b1;
        end
        nxt_st.nco = nco_sum[`RIT_NCO_W-1:0];
        nxt_st.div1_q = st_ff.div1[DIV1_BITS-1];
        // AND/OR select; both or neither select gives no input
        mux_src = (norm_s & ~test_s & st_ff.div1[DIV1_BITS-1])
                | (~norm_s & test_s & tclk_s);
        nxt_st.mux_q = mux_src;
        if (mux_src & ~st_ff.mux_q)
        begin
            nxt_st.div2 = st_ff.div2 + 1'b1;
            if (st_ff.div2 == {DIV2_BITS{1'b1}})
            begin
                nxt_st.tick = 1'b1;
            end
        end
        if (st_ff.tick && !st_ff.zero)
        begin
            // Borrow ripples digit by digit
            nxt_st.cnt.d0 = bcd_dec(st_ff.cnt.d0);
            if (st_ff.cnt.d0 == `RIT_BCD_ZERO)
            begin
                nxt_st.cnt.d1 = bcd_dec(st_ff.cnt.d1);
                if (st_ff.cnt.d1 == `RIT_BCD_ZERO)
                begin
                    nxt_st.cnt.d2 = bcd_dec(st_ff.cnt.d2);
                    if (st_ff.cnt.d2 == `RIT_BCD_ZERO)
                    begin
                        nxt_st.cnt.d3 = bcd_dec(st_ff.cnt.d3);
                    end
                end
            end
        end
        // Counter never leaves zero by itself
        nxt_st.zero = (nxt_st.cnt == '0);
        case (st_ff.state)
            RIT_ST_COUNT:
            begin
                nxt_st.filt = '0;
                if (st_ff.zero)
                begin
                    nxt_st.state = RIT_ST_ZERO;
                end
            end
            RIT_ST_ZERO:
            begin
                // Any drop of zero restarts the filter
                if (!st_ff.zero)
                begin
                    nxt_st.state = RIT_ST_COUNT;
                    nxt_st.filt = '0;
                end
                else if (st_ff.filt == FW'(FILT_CYC - 1))
                begin
                    nxt_st.state = RIT_ST_FIRED;
                    nxt_st.fire = 1'b1;
                end
                else
                begin
                    nxt_st.filt = st_ff.filt + 1'b1;
                end
            end
            RIT_ST_FIRED:
            begin
                nxt_st.fire = 1'b1;
            end
            default:
            begin
                nxt_st.state = RIT_ST_COUNT;
                nxt_st.fire = 1'b0;
            end
        endcase
        // Load has top priority and re-arms the firing stage
        if (load_s)
        begin
            nxt_st.cnt.d3 = bcd_clip(switch_in.d3);
            nxt_st.cnt.d2 = bcd_clip(switch_in.d2);
            nxt_st.cnt.d1 = bcd_clip(switch_in.d1);
            nxt_st.cnt.d0 = bcd_clip(switch_in.d0);
            nxt_st.zero = 1'b0;
            nxt_st.state = RIT_ST_COUNT;
            nxt_st.filt = '0;
            nxt_st.fire = 1'b0;
            nxt_st.div2 = '0;
        end
    end

    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign fire_out      = st_ff.fire;
    assign zero_out      = st_ff.zero;
    assign hour_tick_out = st_ff.tick;
    assign count_out     = st_ff.cnt;
endmodule // rit_timer

//--- testbench/rit_timer_assertions.sv
// Port checker for the release interval timer
module rit_timer_chk #(
    parameter int FILT_CYC = 2
) (
    input wire logic              clk_in,
    input wire logic              sys_rst_in,
    input wire logic              load_in,
    input wire rit_pkg::rit_bcd_t switch_in,
    input wire rit_pkg::rit_sel_t sel_in,
    input wire logic              test_clk_in,
    input wire logic              fire_out,
    input wire logic              zero_out,
    input wire logic              hour_tick_out,
    input wire rit_pkg::rit_bcd_t count_out
);
    import rit_pkg::*;
    logic [5:0] ld_ff;
    int         zrun_ff;
    logic       quiet;
    // Synced load still acts a few cycles after the pin drops
    assign quiet = !load_in && ld_ff == 6'h00;
    always_ff @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            ld_ff   <= 6'h00;
            zrun_ff <= 0;
        end
        else
        begin
            ld_ff   <= {ld_ff[4:0], load_in};
            zrun_ff <= zero_out ? zrun_ff + 1 : 0;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    zero_flag_a: assert property (
        !$past(sys_rst_in) |-> zero_out == (count_out == 16'h0000))
        else $error("zero flag off");
    load_copy_a: assert property (
        $changed(count_out) && !$past(hour_tick_out)
        |-> count_out == switch_in) else $error("count not loaded");
    tick_step_a: assert property (
        hour_tick_out && quiet && count_out.d0 != 4'h0
        |=> count_out == $past(count_out) - 16'h0001)
        else $error("count step off");
    zero_hold_a: assert property (
        hour_tick_out && quiet && count_out == 16'h0000
        |=> count_out == 16'h0000) else $error("count wrapped");
    fire_hold_a: assert property (
        fire_out && quiet |=> fire_out) else $error("fire dropped");
    fire_filter_a: assert property (
        $rose(fire_out) |-> zrun_ff >= FILT_CYC)
        else $error("fire too early");
    fire_delay_a: assert property (
        quiet && zrun_ff > FILT_CYC + 2 |-> fire_out)
        else $error("fire too late");
    tick_pulse_a: assert property (
        hour_tick_out |=> !hour_tick_out) else $error("tick too long");
endmodule // rit_timer_chk

bind rit_timer rit_timer_chk #(.FILT_CYC(FILT_CYC)) chk (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .load_in(load_in),
    .switch_in(switch_in), .sel_in(sel_in), .test_clk_in(test_clk_in),
    .fire_out(fire_out), .zero_out(zero_out),
    .hour_tick_out(hour_tick_out), .count_out(count_out));

//--- testbench/rit_test_set.sv
// Test set model: select controls and accelerated test clock
module rit_test_set (
    input  wire logic         clk_in,
    output rit_pkg::rit_sel_t sel_out,
    output logic              test_clk_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import rit_pkg::*;
    initial
    begin
        sel_out      = 2'b00;
        test_clk_out = 1'b0;
    end
    // Normal is 10, test is 01; equal codes route nothing
    task automatic set_mode(input rit_sel_t m);
        @(posedge clk_in);
        #1 sel_out = m;
    endtask
    // Five cycles a phase keeps clear of the synchroniser
    task automatic pulses(input int n);
        repeat (n)
        begin
            repeat (5) @(posedge clk_in);
            #1 test_clk_out = 1'b1;
            repeat (5) @(posedge clk_in);
            #1 test_clk_out = 1'b0;
        end
    endtask
endmodule // rit_test_set

//--- testbench/tb_top.sv
// Testbench for the release interval timer
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rit_pkg::*;
    logic     clk_in = 1'b0;
    logic     rst = 1'b1;
    logic     load = 1'b0;
    rit_bcd_t sw = 16'h0001;
    rit_sel_t sel;
    logic     tclk, fire, zero, tick;
    rit_bcd_t count;
    int       mismatches = 0;
    int       compares = 0;
    int       cycles = 0;
    int       gap;
    always #5 clk_in = ~clk_in;
    rit_test_set ts (.clk_in(clk_in), .sel_out(sel), .test_clk_out(tclk));
    // Short dividers: 128 cycles per tick in normal mode
    rit_timer #(.DIV1_BITS(2), .DIV2_BITS(3), .FILT_CYC(2),
        .BASE_HZ(25000000)) dut (
        .clk_in(clk_in), .sys_rst_in(rst), .load_in(load),
        .switch_in(sw), .sel_in(sel), .test_clk_in(tclk),
        .fire_out(fire), .zero_out(zero), .hour_tick_out(tick),
        .count_out(count));
    task automatic chk16(input string s, input logic [15:0] e, g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", s, e, g);
        end
    endtask
    task automatic chk1(input string s, input logic e, g);
        chk16(s, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            summarize();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic wait_tick(output int n);
        n = 0;
        do
        begin
            @(negedge clk_in);
            n++;
        end
        while (tick !== 1'b1 && n < 1000);
    endtask
    task automatic load_sw(input rit_bcd_t v);
        ts.set_mode(2'b00);
        sw = v;
        load = 1'b1;
        step(6);
        load = 1'b0;
        step(6);
        chk16("count", v, count);
        chk1("fire", 1'b0, fire);
    endtask
    task automatic t_count();
        load_sw(16'h0010);
        ts.pulses(8);
        step(10);
        chk16("unrouted", 16'h0010, count);
        ts.set_mode(2'b11);
        ts.pulses(8);
        step(10);
        chk16("both selects", 16'h0010, count);
        ts.set_mode(2'b01);
        ts.pulses(8);
        step(10);
        chk16("borrow", 16'h0009, count);
        ts.pulses(64);
        step(10);
        chk1("early fire", 1'b0, fire);
        ts.pulses(8);
        step(10);
        chk1("zero", 1'b1, zero);
        chk1("fire", 1'b1, fire);
        ts.pulses(16);
        step(10);
        chk16("held", 16'h0000, count);
        chk1("fire held", 1'b1, fire);
        load_sw(16'h9999);
        $display("test count done");
    endtask
    task automatic t_norm();
        load_sw(16'h0003);
        ts.set_mode(2'b10);
        wait_tick(gap);
        wait_tick(gap);
        chk16("tick gap", 16'h0080, 16'(gap));
        step(2);
        chk16("count", 16'h0001, count);
        $display("test normal done");
    endtask
    task automatic t_rst();
        load_sw(16'h0002);
        ts.set_mode(2'b01);
        ts.pulses(3);
        rst = 1'b1;
        step(2);
        chk16("reset count", 16'h0000, count);
        chk1("reset fire", 1'b0, fire);
        rst = 1'b0;
        load_sw(16'h0001);
        ts.set_mode(2'b01);
        ts.pulses(8);
        step(10);
        chk1("fire", 1'b1, fire);
        $display("test reset done");
    endtask
    initial
    begin
        repeat (10) @(posedge clk_in);
        #1 rst = 1'b0;
        t_count();
        t_norm();
        t_rst();
        summarize();
    end
endmodule // tb_top
